// *** logic/tdr_bank.v ***
// one 16x1 function generator used as ram
`default_nettype none
module tdr_bank #(
  parameter AW = 4
) (
  // clock
  input wire clk_i,
  // write side
  input wire wr_i,
  input wire [AW-1:0] wa_i,
  input wire wd_i,
  // configuration preload
  input wire load_i,
  input wire [(1<<AW)-1:0] load_val_i,
  // read side
  input wire [AW-1:0] ra_i,
  output reg rd_o
);

  localparam DEPTH = 1 << AW;

  reg [DEPTH-1:0] bits_r;

  // contents start at zero and are never touched by reset
  initial bits_r = {DEPTH{1'b0}};
  initial rd_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (load_i)
      bits_r <= load_val_i;
    else if (wr_i)
      bits_r[wa_i] <= wd_i;
    rd_o <= bits_r[ra_i];
  end

endmodule
`default_nettype wire

// *** logic/tdr_defs.vh ***
// constants for the tile distributed ram block
`ifndef TDR_DEFS_VH
`define TDR_DEFS_VH

// register byte offsets
`define TDR_ADR_CTRL 8'h00
`define TDR_ADR_PRE_F 8'h04
`define TDR_ADR_PRE_G 8'h08
`define TDR_ADR_CMD 8'h0c
`define TDR_ADR_STATUS 8'h10

// control register fields
`define TDR_CTRL_ORG 1:0
`define TDR_CTRL_WFALL 2
`define TDR_CTRL_FFINV 3
`define TDR_CTRL_XSEL 5:4
`define TDR_CTRL_YSEL 7:6
`define TDR_CTRL_HTT 15:8
`define TDR_CTRL_HTT_LSB 8
`define TDR_CTRL_RST 16'h0000
`define TDR_PRE_RST 16'h0000

// command and status fields
`define TDR_CMD_LOAD 0
`define TDR_ST_STALL 0
`define TDR_ST_WADR 5:1
`define TDR_ST_WDAT 6

// organisations
`define TDR_ORG_16X2 2'h0
`define TDR_ORG_16X1 2'h1
`define TDR_ORG_32X1 2'h2

// flip-flop source selects
`define TDR_SEL_F 2'h0
`define TDR_SEL_G 2'h1
`define TDR_SEL_H 2'h2
`define TDR_SEL_D0 2'h3

// write clock stall limit: time in ms, clock in kHz
`define TDR_STALL_MS 1
`define TDR_CLK_KHZ 200000

`endif

// *** logic/tdr_tile.v ***
// logic tile with two function generators usable as distributed ram
//
// The Wishbone register port and the address map were decided locally.
`include "tdr_defs.vh"
`default_nettype none
module tdr_tile #(
  parameter CNT_W = 18,
  parameter [CNT_W-1:0] STALL_CYC = `TDR_STALL_MS * `TDR_CLK_KHZ
) (
  // clock and global_set_reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // logic_tile pins
  input wire tile_clk_i,
  input wire we_i,
  input wire [3:0] f_in_i,
  input wire [3:0] g_in_i,
  input wire direct_input_zero_i,
  input wire direct_input_one_i,
  // generator and flop outputs
  output reg f_port_read_output_o,
  output reg g_port_read_output_o,
  output reg h_out_o,
  output reg ff_x_o,
  output reg ff_y_o
);

  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] sel;
    begin
      merge16 = old_v;
      if (sel[0])
        merge16[7:0] = new_v[7:0];
      if (sel[1])
        merge16[15:8] = new_v[15:8];
    end
  endfunction

  function pick;
    input [1:0] sel;
    input f_v;
    input g_v;
    input h_v;
    input d0_v;
    begin
      case (sel)
        `TDR_SEL_F: pick = f_v;
        `TDR_SEL_G: pick = g_v;
        `TDR_SEL_H: pick = h_v;
        default: pick = d0_v;
      endcase
    end
  endfunction

  reg [15:0] ctrl_r;
  reg [15:0] pre_f_r;
  reg [15:0] pre_g_r;
  reg load_r;
  reg stall_r;
  reg [4:0] last_wa_r;
  reg last_wd_r;
  reg [10:0] pin_s1_r;
  reg [10:0] pin_s2_r;
  reg k_prev_r;
  reg [3:0] cap_fa_r;
  reg [3:0] cap_ga_r;
  reg cap_d0_r;
  reg cap_d1_r;
  reg wr_pulse_r;
  reg d1_q_r;
  reg armed_r;
  reg [CNT_W-1:0] cnt_r;
  reg [31:0] rdat_nxt;
  wire rd_f;
  wire rd_g;

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins
  wire [3:0] fa_s = pin_s2_r[3:0];
  wire [3:0] ga_s = pin_s2_r[7:4];
  wire d0_s = pin_s2_r[8];
  wire d1_s = pin_s2_r[9];
  wire k_s = pin_s2_r[10];
  reg we_i_s1;
  reg we_i_s2;
  wire we_s = we_i_s2;

  wire [1:0] org = ctrl_r[`TDR_CTRL_ORG];
  wire org32 = (org == `TDR_ORG_32X1);
  wire org16x1 = (org == `TDR_ORG_16X1);
  wire k_rise = k_s & ~k_prev_r;
  wire k_fall = ~k_s & k_prev_r;
  wire wr_edge = ctrl_r[`TDR_CTRL_WFALL] ? k_fall : k_rise;
  wire ff_edge = ctrl_r[`TDR_CTRL_FFINV] ? k_fall : k_rise;
  wire post_phase = ctrl_r[`TDR_CTRL_WFALL] ? ~k_s : k_s;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wreq = req & wb_we_i;
  wire stall_set = armed_r & post_phase & (cnt_r >= STALL_CYC - 1'b1);
  wire stall_clr = wreq & (wb_adr_i == `TDR_ADR_STATUS) & wb_sel_i[0] & wb_dat_i[`TDR_ST_STALL];

  // sync chain keeps tracking through reset so no false clock edge follows it
  always @(posedge clk_i)
  begin
    pin_s1_r <= {tile_clk_i, direct_input_one_i, direct_input_zero_i, g_in_i, f_in_i};
    pin_s2_r <= pin_s1_r;
    we_i_s1 <= we_i;
    we_i_s2 <= we_i_s1;
    k_prev_r <= k_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // write capture and internal write pulse
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_fa_r <= 4'h0;
      cap_ga_r <= 4'h0;
      cap_d0_r <= 1'b0;
      cap_d1_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      last_wa_r <= 5'h00;
      last_wd_r <= 1'b0;
    end
    else
    begin
      if (wr_edge)
      begin
        cap_fa_r <= fa_s;
        cap_ga_r <= ga_s;
        cap_d0_r <= d0_s;
        cap_d1_r <= d1_s;
      end
      wr_pulse_r <= wr_edge & we_s;
      if (wr_pulse_r)
      begin
        last_wa_r <= {org32 & cap_d1_r, cap_fa_r};
        last_wd_r <= cap_d0_r;
      end
    end
  end

  // bank write steering per organisation
  wire f_wr = wr_pulse_r & ~(org32 & cap_d1_r);
  wire g_wr = wr_pulse_r & ~org16x1 & (~org32 | cap_d1_r);
  wire [3:0] g_wa = org32 ? cap_fa_r : cap_ga_r;
  wire g_wd = org32 ? cap_d0_r : cap_d1_r;
  wire [3:0] g_ra = org32 ? fa_s : ga_s;

  tdr_bank #(.AW(4)) u_bank_f (
    .clk_i(clk_i),
    .wr_i(f_wr),
    .wa_i(cap_fa_r),
    .wd_i(cap_d0_r),
    .load_i(load_r),
    .load_val_i(pre_f_r),
    .ra_i(fa_s),
    .rd_o(rd_f)
  );

  tdr_bank #(.AW(4)) u_bank_g (
    .clk_i(clk_i),
    .wr_i(g_wr),
    .wa_i(g_wa),
    .wd_i(g_wd),
    .load_i(load_r),
    .load_val_i(pre_g_r),
    .ra_i(g_ra),
    .rd_o(rd_g)
  );

  ////////////////////////////////////////////////////////////////////////
  // read outputs, third generator and tile flops
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      d1_q_r <= 1'b0;
      f_port_read_output_o <= 1'b0;
      g_port_read_output_o <= 1'b0;
      h_out_o <= 1'b0;
      ff_x_o <= 1'b0;
      ff_y_o <= 1'b0;
    end
    else
    begin
      d1_q_r <= d1_s;
      f_port_read_output_o <= (org32 & d1_q_r) ? rd_g : rd_f;
      g_port_read_output_o <= org16x1 ? 1'b0 : rd_g;
      h_out_o <= ctrl_r[`TDR_CTRL_HTT_LSB + {rd_f, rd_g, d1_q_r}];
      if (ff_edge)
      begin
        ff_x_o <= pick(ctrl_r[`TDR_CTRL_XSEL], f_port_read_output_o, g_port_read_output_o, h_out_o, d0_s);
        ff_y_o <= pick(ctrl_r[`TDR_CTRL_YSEL], f_port_read_output_o, g_port_read_output_o, h_out_o, d0_s);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write clock stall monitor
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      armed_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
      stall_r <= 1'b0;
    end
    else
    begin
      if (wr_edge)
      begin
        armed_r <= 1'b1;
        cnt_r <= {CNT_W{1'b0}};
      end
      else if (~post_phase)
        armed_r <= 1'b0;
      else if (armed_r & ~stall_set)
        cnt_r <= cnt_r + 1'b1;
      stall_r <= stall_set | (stall_r & ~stall_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone registers
  always @*
  begin
    rdat_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `TDR_ADR_CTRL: rdat_nxt[15:0] = ctrl_r;
      `TDR_ADR_PRE_F: rdat_nxt[15:0] = pre_f_r;
      `TDR_ADR_PRE_G: rdat_nxt[15:0] = pre_g_r;
      `TDR_ADR_STATUS:
      begin
        rdat_nxt[`TDR_ST_STALL] = stall_r;
        rdat_nxt[`TDR_ST_WADR] = last_wa_r;
        rdat_nxt[`TDR_ST_WDAT] = last_wd_r;
      end
      default: rdat_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `TDR_CTRL_RST;
      pre_f_r <= `TDR_PRE_RST;
      pre_g_r <= `TDR_PRE_RST;
      load_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdat_nxt : 32'h0000_0000;
      load_r <= wreq & (wb_adr_i == `TDR_ADR_CMD) & wb_sel_i[0] & wb_dat_i[`TDR_CMD_LOAD];
      if (wreq)
      begin
        case (wb_adr_i)
          `TDR_ADR_CTRL: ctrl_r <= merge16(ctrl_r, wb_dat_i[15:0], wb_sel_i[1:0]);
          `TDR_ADR_PRE_F: pre_f_r <= merge16(pre_f_r, wb_dat_i[15:0], wb_sel_i[1:0]);
          `TDR_ADR_PRE_G: pre_g_r <= merge16(pre_g_r, wb_dat_i[15:0], wb_sel_i[1:0]);
          default: ctrl_r <= ctrl_r;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/tdr_tile_end.v ***
// holds no logic of its own
`default_nettype none
`default_nettype wire

// *** sim/tdr_fabric_model.sv ***
// fabric logic driving the tile pins
`default_nettype none
module tdr_fabric_model (
  input wire logic clk_i,
  output logic tck_o, we_o, d0_o, d1_o,
  output logic [3:0] fa_o, ga_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pol = 1'b0;
  initial {tck_o, we_o, d0_o, d1_o, fa_o, ga_o} = 12'h0;
  // data held around the active edge, inverted before the return edge, then restored with we low
  task automatic wr(input logic [3:0] f, g, input logic a, b, w);
    @(posedge clk_i);
    fa_o <= f;
    ga_o <= g;
    {d0_o, d1_o, we_o} <= {a, b, w};
    repeat (3) @(posedge clk_i);
    tck_o <= ~pol;
    repeat (3) @(posedge clk_i);
    {d0_o, d1_o, we_o} <= ~{a, b, w};
    repeat (3) @(posedge clk_i);
    tck_o <= pol;
    repeat (3) @(posedge clk_i);
    {d0_o, d1_o, we_o} <= {a, b, 1'b0};
  endtask
  // clock held in the post-edge phase for n cycles on purpose, then returned to its idle level
  task automatic park(input int n);
    @(posedge clk_i);
    tck_o <= ~pol;
    repeat (n) @(posedge clk_i);
    tck_o <= pol;
  endtask
  task automatic setpol(input logic p);
    @(posedge clk_i);
    pol = p;
    tck_o <= p;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** sim/tdr_tile_properties.sv ***
// port assertions for the tile ram
`default_nettype none
module tdr_tile_props (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tile_clk_i, we_i,
  input wire logic direct_input_zero_i, direct_input_one_i,
  input wire logic [3:0] f_in_i, g_in_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic f_port_read_output_o, g_port_read_output_o, h_out_o, ff_x_o, ff_y_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [12:0] pins = {tile_clk_i, we_i, direct_input_zero_i, direct_input_one_i, f_in_i, g_in_i, wb_ack_o};
  logic [12:0] pins_r;
  logic [3:0] quiet_r;
  always_ff @(posedge clk_i)
  begin
    pins_r <= pins;
    quiet_r <= (rst_i || pins != pins_r) ? 4'h0 : (quiet_r == 4'hf ? 4'hf : quiet_r + 4'h1);
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_ram_hold: assert property (quiet_r >= 4'ha |-> $stable({f_port_read_output_o, g_port_read_output_o, h_out_o}))
    else $error("ram output moved with no cause");
  a_ff_hold: assert property (quiet_r >= 4'ha |-> $stable(ff_x_o) && $stable(ff_y_o))
    else $error("tile flop moved without clock edge");
  a_reset_quiet: assert property ($fell(rst_i) |-> {wb_ack_o, h_out_o, ff_x_o, ff_y_o} == 4'h0)
    else $error("outputs not clear after reset");
  c_bus_write: cover property (wb_ack_o && wb_we_i);
  c_ram_one: cover property ($rose(f_port_read_output_o));
  c_flop_one: cover property ($rose(ff_x_o));
endmodule
bind tdr_tile tdr_tile_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .tile_clk_i,
  .we_i, .direct_input_zero_i, .direct_input_one_i, .f_in_i, .g_in_i, .wb_dat_o, .f_port_read_output_o,
  .g_port_read_output_o, .h_out_o, .ff_x_o, .ff_y_o);
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the tile ram
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire logic ack, tck, twe, d0, d1, fo, go, ho, fx, fy;
  wire logic [3:0] fa, ga;
  wire logic [31:0] dout;
  int num_errors = 0, n_tests = 0;
  logic [7:0] adr_l [6] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10, 8'h14};
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
  tdr_tile #(.STALL_CYC(18'h14)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .tile_clk_i(tck),
    .we_i(twe), .f_in_i(fa), .g_in_i(ga), .direct_input_zero_i(d0), .direct_input_one_i(d1),
    .f_port_read_output_o(fo), .g_port_read_output_o(go), .h_out_o(ho), .ff_x_o(fx), .ff_y_o(fy));
  tdr_fabric_model u_fab (.clk_i, .tck_o(tck), .we_o(twe), .d0_o(d0), .d1_o(d1), .fa_o(fa), .ga_o(ga));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dout;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic tw(input logic [3:0] f, g, input logic a, b, w);
    u_fab.wr(f, g, a, b, w);
    repeat (10) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    foreach (adr_l[i])
    begin
      wb(0, adr_l[i], 32'h0);
      `CHK(rd, 32'h0)
    end
    $display("end registers");
    tw(5, 3, 1, 1, 0);
    `CHK({fo, go}, 2'b00)
    tw(5, 3, 1, 1, 1);
    `CHK({fo, go}, 2'b11)
    wb(1, 8'h0, 32'h4);
    u_fab.setpol(1);
    tw(7, 7, 1, 1, 1);
    `CHK({fo, go}, 2'b11)
    wb(1, 8'h0, 32'h2);
    u_fab.setpol(0);
    tw(2, 0, 1, 1, 1);
    `CHK(fo, 1'b1)
    tw(2, 0, 0, 0, 0);
    `CHK(fo, 1'b0)
    wb(1, 8'h0, 32'h1);
    tw(9, 9, 1, 1, 1);
    `CHK({fo, go}, 2'b10)
    $display("end writes");
    wb(1, 8'h4, 32'h8000);
    wb(1, 8'h8, 32'h0001);
    wb(1, 8'h0, 32'h30);
    wb(1, 8'hc, 32'h1);
    tw(15, 0, 0, 0, 0);
    `CHK({fo, go}, 2'b11)
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 8'h0, 32'h30);
    tw(15, 0, 1, 0, 0);
    `CHK({fo, go}, 2'b11)
    `CHK({fx, fy}, 2'b11)
    u_fab.park(40);
    wb(0, 8'h10, 32'h0);
    `CHK(rd[0], 1'b1)
    wb(1, 8'h10, 32'h1);
    wb(0, 8'h10, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("end preload and stall");
    wb(1, 8'h0, 32'h80b8);
    tw(15, 0, 1, 1, 0);
    `CHK(ho, 1'b1)
    `CHK({fx, fy}, 2'b00)
    tw(15, 0, 1, 0, 0);
    `CHK(ho, 1'b0)
    `CHK({fx, fy}, 2'b01)
    $display("end third generator and flop edge");
    tally_and_finish;
  end
  initial
  begin
    repeat (6000) @(posedge clk_i);
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
